// file: dsbr_map.vh
`ifndef DSBR_MAP_VH
`define DSBR_MAP_VH
// Register selectors on the serial command side.
`define DSBR_SEL_STATUS 2'h0
`define DSBR_SEL_BKPT 2'h1
`define DSBR_SEL_FRST 2'h2
// Field positions of debug_status_control.
`define DSBR_BIT_DBG_EN 7
`define DSBR_BIT_ACTIVE 6
`define DSBR_BIT_BRK_EN 5
`define DSBR_BIT_TAG_SEL 4
`define DSBR_BIT_CLK_SEL 3
`define DSBR_BIT_SLEEP 2
`define DSBR_BIT_SLEEP_FAIL 1
`define DSBR_BIT_SLOW_FAIL 0
// Field position of the forced-reset control bit.
`define DSBR_BIT_FRST_GO 0
// Reset values, and the fixed read value of the forced-reset register.
`define DSBR_STATUS_RST 8'h00
`define DSBR_BKPT_RST 16'h0000
`define DSBR_FRST_READ 8'h00
`endif

// file: dsbr_bkpt_store.v
`timescale 1ns/1ps
`include "dsbr_map.vh"
// Breakpoint match storage, reachable only from serial commands.
module dsbr_bkpt_store (
    input wire i_sys_clk,
    input wire i_reset,
    input wire i_wr,
    input wire [15:0] i_wdata,
    output reg [15:0] o_rdata
);
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
            o_rdata <= `DSBR_BKPT_RST;
        else if (i_wr)
            o_rdata <= i_wdata;
    end
endmodule // dsbr_bkpt_store

// file: dsbr_debug_regs.v
`timescale 1ns/1ps
`include "dsbr_map.vh"
// Functional notes
// - wait_stop_status reads 1 in wait/stop or after a halt pulled the core out of it, else 0.
// - Commands other than the halt are refused while the core is in wait or stop.
// - A halt command during wait or stop forces the core into active debug mode.
// - wait_stop_failure is set when a memory access command collides with wait or stop.
// - data_valid_failure always reads 0 since no slow memory exists.
// - A 16-bit breakpoint match register holds the breakpoint address.
// - breakpoint_enable gates the breakpoint match; force_tag_select only drives o_tag_mode.
// - The breakpoint register is reached only by the breakpoint read and write commands.
// - The forced-reset bit is written only by a serial memory-write command.
// - User program writes to the forced-reset register are ignored.
// - Reads of the forced-reset register always return 0x00.
module dsbr_debug_regs (
    input wire i_sys_clk,
    input wire i_reset,
    input wire i_cpu_wait_stop,
    input wire i_cmd_valid,
    input wire i_cmd_halt,
    input wire i_cmd_mem,
    input wire i_mem_fail_sleep,
    input wire i_cmd_wr,
    input wire i_cmd_rd,
    input wire [1:0] i_cmd_sel,
    input wire [15:0] i_cmd_wdata,
    input wire i_cpu_wr,
    input wire [1:0] i_cpu_sel,
    input wire [7:0] i_cpu_wdata,
    input wire [15:0] i_cpu_addr,
    input wire i_cpu_fetch,
    output reg [15:0] o_cmd_rdata,
    output wire o_cmd_accept,
    output wire o_cmd_refused,
    output reg o_halt_request,
    output reg o_force_reset,
    output reg o_bkpt_hit,
    output wire o_tag_mode,
    output wire o_debug_active
);
    // ****************************************
    // Declarations
    // ****************************************
    reg [7:0] status_ctl;
    reg [7:0] next_status_ctl;
    reg sleep_latched;
    reg next_sleep_latched;
    reg next_halt_request;
    reg next_force_reset;
    reg next_bkpt_hit;
    reg [15:0] next_cmd_rdata;

    wire [15:0] bkpt_addr;
    wire sleep_now;
    wire cmd_ok;
    wire halt_go;
    wire status_wr;
    wire status_rd;
    wire bkpt_wr;
    wire bkpt_rd;
    wire frst_wr;
    wire frst_rd;
    wire any_rd;
    wire fail_event;
    wire unused_cpu;

    // ****************************************
    // Functions
    // ****************************************
    // One decoder for every register strobe keeps the accept gate identical on all of them.
    function reg_strobe;
        input ok;
        input op;
        input [1:0] sel;
        input [1:0] code;
        begin
            reg_strobe = ok & op & (sel == code);
        end
    endfunction

    // Only the host-writable control bits follow the write data; the flags keep their state.
    function [7:0] control_merge;
        input [7:0] old;
        input [15:0] wdata;
        begin
            control_merge = old;
            control_merge[`DSBR_BIT_DBG_EN] = wdata[`DSBR_BIT_DBG_EN];
            control_merge[`DSBR_BIT_BRK_EN] = wdata[`DSBR_BIT_BRK_EN];
            control_merge[`DSBR_BIT_TAG_SEL] = wdata[`DSBR_BIT_TAG_SEL];
            control_merge[`DSBR_BIT_CLK_SEL] = wdata[`DSBR_BIT_CLK_SEL];
        end
    endfunction

    // Read image of status: the sleep bit is live, and the slow-memory flag is tied low.
    function [15:0] status_image;
        input [7:0] ctl;
        input sleep;
        begin
            status_image = {8'h00, ctl};
            status_image[`DSBR_BIT_SLEEP] = sleep;
            status_image[`DSBR_BIT_SLOW_FAIL] = 1'b0;
        end
    endfunction

    // A fetch matches only when the breakpoint logic is enabled and the whole address agrees.
    function bkpt_match;
        input enable;
        input fetch;
        input [15:0] addr;
        input [15:0] target;
        begin
            bkpt_match = enable & fetch & (addr == target);
        end
    endfunction

    // ****************************************
    // Command gate
    // ****************************************
    assign sleep_now = i_cpu_wait_stop | sleep_latched;
    // The halt is the only command that may pass while the core sleeps.
    assign cmd_ok = i_cmd_valid & (~i_cpu_wait_stop | i_cmd_halt);
    assign o_cmd_accept = cmd_ok;
    assign o_cmd_refused = i_cmd_valid & ~cmd_ok;
    assign halt_go = cmd_ok & i_cmd_halt;
    assign status_wr = reg_strobe(cmd_ok, i_cmd_wr, i_cmd_sel, `DSBR_SEL_STATUS);
    assign status_rd = reg_strobe(cmd_ok, i_cmd_rd, i_cmd_sel, `DSBR_SEL_STATUS);
    assign bkpt_wr = reg_strobe(cmd_ok, i_cmd_wr, i_cmd_sel, `DSBR_SEL_BKPT);
    assign bkpt_rd = reg_strobe(cmd_ok, i_cmd_rd, i_cmd_sel, `DSBR_SEL_BKPT);
    assign frst_wr = reg_strobe(cmd_ok, i_cmd_wr, i_cmd_sel, `DSBR_SEL_FRST);
    assign frst_rd = reg_strobe(cmd_ok, i_cmd_rd, i_cmd_sel, `DSBR_SEL_FRST);
    // The spare selector still counts as a read so that it returns zero.
    assign any_rd = cmd_ok & i_cmd_rd;
    assign fail_event = i_cmd_mem & i_mem_fail_sleep;
    assign o_debug_active = status_ctl[`DSBR_BIT_ACTIVE];
    assign o_tag_mode = status_ctl[`DSBR_BIT_TAG_SEL];

    // ****************************************
    // Status and control
    // ****************************************
    always @*
    begin
        next_status_ctl = status_ctl;
        next_sleep_latched = sleep_latched;
        if (halt_go)
        begin
            next_status_ctl[`DSBR_BIT_ACTIVE] = 1'b1;
            // Remember that the halt broke a wait or stop, so the flag survives the wake-up.
            next_sleep_latched = i_cpu_wait_stop;
        end
        if (status_wr)
        begin
            next_status_ctl = control_merge(next_status_ctl, i_cmd_wdata);
            // Leaving debug mode by writing the active flag low also drops the latched state.
            if (!i_cmd_wdata[`DSBR_BIT_ACTIVE] && !i_cmd_halt)
            begin
                next_status_ctl[`DSBR_BIT_ACTIVE] = 1'b0;
                next_sleep_latched = 1'b0;
            end
        end
        // A read of status clears the failure flag, but a new failure in the same cycle wins.
        if (fail_event)
        begin
            next_status_ctl[`DSBR_BIT_SLEEP_FAIL] = 1'b1;
        end
        else if (status_rd)
        begin
            next_status_ctl[`DSBR_BIT_SLEEP_FAIL] = 1'b0;
        end
    end

    // Bits 2 and 0 are never set here; the read image supplies them.
    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            status_ctl <= `DSBR_STATUS_RST;
            sleep_latched <= 1'b0;
        end
        else
        begin
            status_ctl <= next_status_ctl;
            sleep_latched <= next_sleep_latched;
        end
    end

    // ****************************************
    // Halt request
    // ****************************************
    // The pulse lasts one cycle per cycle of accepted halt whether or not the core was asleep; the core side decides how to stop.
    always @*
    begin
        next_halt_request = halt_go;
    end

    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_halt_request <= 1'b0;
        end
        else
        begin
            o_halt_request <= next_halt_request;
        end
    end

    // ****************************************
    // Breakpoint
    // ****************************************
    // Storage sits in its own module so that only the serial command strobes can reach it.
    dsbr_bkpt_store u_bkpt (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_wr(bkpt_wr),
        .i_wdata(i_cmd_wdata),
        .o_rdata(bkpt_addr)
    );

    always @*
    begin
        next_bkpt_hit = bkpt_match(status_ctl[`DSBR_BIT_BRK_EN], i_cpu_fetch, i_cpu_addr, bkpt_addr);
    end

    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_bkpt_hit <= 1'b0;
        end
        else
        begin
            o_bkpt_hit <= next_bkpt_hit;
        end
    end

    // ****************************************
    // Forced reset
    // ****************************************
    // The CPU write port is deliberately left out here: user code must never be able to reset the part.
    always @*
    begin
        next_force_reset = frst_wr & i_cmd_wdata[`DSBR_BIT_FRST_GO];
    end

    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_force_reset <= 1'b0;
        end
        else
        begin
            o_force_reset <= next_force_reset;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Read data stands until the next accepted read, so a refused read leaves it untouched.
    always @*
    begin
        next_cmd_rdata = o_cmd_rdata;
        if (status_rd)
        begin
            next_cmd_rdata = status_image(status_ctl, sleep_now);
        end
        else if (bkpt_rd)
        begin
            next_cmd_rdata = bkpt_addr;
        end
        else if (frst_rd)
        begin
            next_cmd_rdata = {8'h00, `DSBR_FRST_READ};
        end
        else if (any_rd)
        begin
            // The spare selector reads as zero rather than holding stale data.
            next_cmd_rdata = 16'h0000;
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_cmd_rdata <= 16'h0000;
        end
        else
        begin
            o_cmd_rdata <= next_cmd_rdata;
        end
    end

    // ****************************************
    // Unused inputs
    // ****************************************
    // The user write port is kept on the boundary but feeds nothing that can change state.
    assign unused_cpu = i_cpu_wr ^ (^i_cpu_sel) ^ (^i_cpu_wdata);
endmodule // dsbr_debug_regs

// file: dsbr_debug_regs_assertions.sv
`timescale 1ns/1ps
module dsbr_debug_regs_assertions (
    input wire i_sys_clk, input wire i_reset, input wire i_cpu_wait_stop, input wire i_cmd_valid,
    input wire i_cmd_halt, input wire i_cmd_wr, input wire i_cmd_rd, input wire [1:0] i_cmd_sel,
    input wire [15:0] i_cmd_wdata, input wire [15:0] o_cmd_rdata, input wire o_cmd_accept,
    input wire o_cmd_refused, input wire o_halt_request, input wire o_force_reset,
    input wire o_tag_mode, input wire o_debug_active
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    wire acc = i_cmd_valid && o_cmd_accept;
    chk_sleep_refuse: assert property (
        i_cmd_valid && i_cpu_wait_stop && !i_cmd_halt |-> o_cmd_refused && !o_cmd_accept) else $error("refuse");
    chk_awake_taken: assert property (
        i_cmd_valid && !i_cpu_wait_stop |-> o_cmd_accept) else $error("accept");
    chk_halt_taken: assert property (
        i_cmd_valid && i_cmd_halt |-> o_cmd_accept ##1 o_halt_request) else $error("halt");
    chk_halt_active: assert property (
        acc && i_cmd_halt |-> ##[1:2] o_debug_active) else $error("active");
    chk_slow_fail_zero: assert property (
        acc && i_cmd_rd && i_cmd_sel == 2'h0 |=> !o_cmd_rdata[0]) else $error("slow flag");
    chk_frst_zero: assert property (
        acc && i_cmd_rd && i_cmd_sel == 2'h2 |=> o_cmd_rdata == 16'h0000) else $error("frst read");
    chk_frst_cause: assert property (
        o_force_reset |-> $past(acc && i_cmd_wr && i_cmd_sel == 2'h2 && i_cmd_wdata[0])) else $error("frst");
    chk_tag_follow: assert property (
        acc && i_cmd_wr && i_cmd_sel == 2'h0 |=> o_tag_mode == $past(i_cmd_wdata[4])) else $error("tag");
    cover property (acc && i_cmd_halt && i_cpu_wait_stop);
    cover property (o_force_reset);
    cover property (o_cmd_refused);
endmodule // dsbr_debug_regs_assertions

// file: dsbr_host_model.sv
`timescale 1ns/1ps
module dsbr_host_model (
    input wire i_sys_clk,
    output reg [3:0] o_kind,
    output reg [1:0] o_sel,
    output reg [15:0] o_wdata
);
    initial
    begin
        {o_kind, o_sel, o_wdata} = 22'h00_0000;
    end
    // One command per call, released after one edge; data is inverted after release so no stale value lingers.
    task cmd(input [3:0] k, input [1:0] s, input [15:0] d);
    begin
        @(negedge i_sys_clk);
        {o_kind, o_sel, o_wdata} = {k, s, d};
        @(negedge i_sys_clk);
        o_kind = 4'h0;
        o_wdata = ~d;
    end
    endtask
endmodule // dsbr_host_model

// file: dsbr_debug_regs_tb.sv
`timescale 1ns/1ps
module dsbr_debug_regs_tb;
    reg i_sys_clk = 0, i_reset = 1, sleep = 0, mem = 0, memf = 0, cwr = 0, fetch = 0;
    reg [15:0] addr = 16'h0000;
    reg [39:0] rows [0:6];
    wire [3:0] k;
    wire [1:0] s;
    wire [15:0] d, rdata;
    wire hreq, frst, hit, tag, act;
    integer errors = 0, check_count = 0, cyc = 0, i;
    initial forever #20 i_sys_clk = ~i_sys_clk;
    dsbr_host_model u_dsbr_host_model (.i_sys_clk(i_sys_clk), .o_kind(k), .o_sel(s), .o_wdata(d));
    dsbr_debug_regs u_dsbr_debug_regs (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_cpu_wait_stop(sleep),
        .i_cmd_valid(k[3]), .i_cmd_halt(k[2]), .i_cmd_mem(mem), .i_mem_fail_sleep(memf), .i_cmd_wr(k[1]),
        .i_cmd_rd(k[0]), .i_cmd_sel(s), .i_cmd_wdata(d), .i_cpu_wr(cwr), .i_cpu_sel(2'h2),
        .i_cpu_wdata(8'hff), .i_cpu_addr(addr), .i_cpu_fetch(fetch), .o_cmd_rdata(rdata), .o_cmd_accept(),
        .o_cmd_refused(), .o_halt_request(hreq), .o_force_reset(frst), .o_bkpt_hit(hit), .o_tag_mode(tag),
        .o_debug_active(act));
    task chk(input [63:0] n, input [15:0] e, input [15:0] g);
    begin
        check_count = check_count + 1;
        if (e !== g)
        begin
            errors = errors + 1;
            $display("unexpected %0s: expected %h seen %h", n, e, g);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    always @(posedge i_sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            errors = errors + 1;
            end_sim;
        end
    end
    initial
    begin
        // Row: kind, selector, write data, check kind (1 read data, 2 force reset, 3 tag), expected.
        rows[0] = {4'ha, 2'h1, 16'h1234, 2'h0, 16'h0000};
        rows[1] = {4'h9, 2'h1, 16'h0000, 2'h1, 16'h1234};
        rows[2] = {4'ha, 2'h1, 16'hffff, 2'h0, 16'h0000};
        rows[3] = {4'h9, 2'h1, 16'h0000, 2'h1, 16'hffff};
        rows[4] = {4'ha, 2'h2, 16'h0001, 2'h2, 16'h0001};
        rows[5] = {4'h9, 2'h2, 16'h0000, 2'h1, 16'h0000};
        rows[6] = {4'ha, 2'h0, 16'h00f0, 2'h3, 16'h0001};
        repeat (20) @(negedge i_sys_clk);
        i_reset = 0;
        chk("rdata", 16'h0000, rdata);
        chk("active", 16'h0000, {15'h0000, act});
        u_dsbr_host_model.cmd(4'ha, 2'h0, 16'h0080);
        u_dsbr_host_model.cmd(4'hc, 2'h0, 16'h0000);
        u_dsbr_host_model.cmd(4'h9, 2'h0, 16'h0000);
        chk("status", 16'h0040, rdata & 16'h0047);
        $display("reset and halt done");
        for (i = 0; i < 7; i = i + 1)
        begin
            u_dsbr_host_model.cmd(rows[i][39:36], rows[i][35:34], rows[i][33:18]);
            if (rows[i][17:16] != 2'h0)
                chk("row", rows[i][15:0], rows[i][17:16] == 2'h1 ? rdata : {15'h0000, rows[i][16] ? tag : frst});
        end
        $display("rows done");
        cwr = 1;
        repeat (3) @(negedge i_sys_clk);
        chk("frst", 16'h0000, {15'h0000, frst});
        cwr = 0;
        addr = 16'hffff;
        fetch = 1;
        @(negedge i_sys_clk);
        chk("hit", 16'h0001, {15'h0000, hit});
        addr = 16'h1234;
        @(negedge i_sys_clk);
        chk("miss", 16'h0000, {15'h0000, hit});
        fetch = 0;
        sleep = 1;
        u_dsbr_host_model.cmd(4'h9, 2'h1, 16'h0000);
        chk("refused", 16'h0000, rdata);
        mem = 1;
        memf = 1;
        @(negedge i_sys_clk);
        mem = 0;
        memf = 0;
        u_dsbr_host_model.cmd(4'hc, 2'h0, 16'h0000);
        chk("halt", 16'h0001, {15'h0000, hreq});
        sleep = 0;
        u_dsbr_host_model.cmd(4'h9, 2'h0, 16'h0000);
        chk("status", 16'h0046, rdata & 16'h0047);
        u_dsbr_host_model.cmd(4'h9, 2'h0, 16'h0000);
        chk("status", 16'h0044, rdata & 16'h0047);
        $display("sleep tests done");
        end_sim;
    end
endmodule // dsbr_debug_regs_tb
bind dsbr_debug_regs dsbr_debug_regs_assertions u_dsbr_debug_regs_assertions (.*);
